// [hw/pmt_control.sv]
// What this block does
// (R1) ut3 bits 7:4 pick expiry period
// (R2) ut3 bits 3:2 pick stop delay
// (R3) throttle bits 7:4 set low time
// (R4) throttle bits 3:0 set high time
// (R5) control one bit 7 master enable
// (R6) control one bit 6 hardware management enable
// (R7) control one bit 5 software management enable
// (R8) control one bits 3..1 enable user timers
// (R9) control one bit 0 suspend event monitoring
// (R10) control two bit 7 resets standby, self-clears
// (R11) control two bit 6 stops suspend timer
// (R12) suspend re-enable restarts count, interrupts again
// (R13) control two bit 5 quick power-down enable
// (R14) control two bit 4 video event scope
// (R15) control two bits 3..0 nmi monitoring
// (R16) suspend expiry interrupts only when enabled
// (R17) timers count, restart on activity, flag expiry
module pmt_control #(
  parameter int MS_US = pmt_pkg::MS_US  // us ticks per ms tick
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        reset,
  // avalon-mm slave
  input  wire logic [9:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // codes held by neighbouring registers
  input  wire logic [3:0]  ut1_code,
  input  wire logic [3:0]  ut2_code,
  input  wire logic [3:0]  suspend_code,
  input  wire logic [3:0]  standby_code,
  input  wire logic        suspend_irq_en,
  input  wire logic        throttle_en,
  // activity sources
  input  wire logic        activity_event,
  input  wire logic        video_mem_access,
  input  wire logic        video_io_access,
  input  wire logic        nmi,
  input  wire logic        reduced_clock_state,
  // to the processor and power logic
  output logic             management_interrupt,
  output logic             clock_stop_request,
  output logic             quick_power_down_en,
  output logic [4:0]       timer_expired
);
  // register file
  logic [7:0] ut3_r, ut3_nxt;    // user timer 3 count and stop delay
  logic [7:0] thr_r, thr_nxt;    // throttle low and high time
  logic [7:0] c1_r, c1_nxt;      // control one
  logic [7:0] c2_r, c2_nxt;      // control two
  logic       ack_r, ack_nxt;    // bus answer in second cycle
  logic [31:0] rd_r, rd_nxt;     // registered read data
  logic [7:0]  idx;              // word index of the access
  // time base
  logic [3:0]  us_div_r, us_div_nxt;
  logic [9:0]  ms_div_r, ms_div_nxt;
  logic        us_tick, ms_tick;
  // throttle and stop delay
  pmt_pkg::pmt_thr_e thr_st_r, thr_st_nxt;
  logic [pmt_pkg::US_W-1:0] thr_cnt_r, thr_cnt_nxt;
  logic [pmt_pkg::US_W-1:0] stop_cnt_r, stop_cnt_nxt;
  logic        stop_r, stop_nxt;   // delayed clock stop
  logic        irq_r, irq_nxt;     // interrupt pulse
  // decoded controls
  logic        pm_en, video_event, act, sby_nxt_clear;
  logic [4:0]  tmr_run, tmr_rst;
  logic [4:0]  tmr_exp, tmr_done;
  logic [3:0]  tmr_code [5];

  pmt_timer_if tif [5] ();

  assign idx = avs_address[9:2];

  // bus answer: one wait cycle, then ack
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign avs_readdata    = rd_r;

  // read mux decoded once for all registers
  function automatic logic [7:0] rd_sel(input logic [7:0] i, input logic [7:0] a, input logic [7:0] b,
                                        input logic [7:0] c, input logic [7:0] d);
    logic [7:0] v;
    v = 8'h00;
    if (i == pmt_pkg::IDX_UT3_STOP) v = a;
    else if (i == pmt_pkg::IDX_THROTTLE) v = b;
    else if (i == pmt_pkg::IDX_CTL_ONE) v = c;
    else if (i == pmt_pkg::IDX_CTL_TWO) v = d;
    return v;
  endfunction

  // register writes, reads, standby reset self-clear
  always_comb begin
    logic wr;
    wr       = avs_write & ack_r & avs_byteenable[0];  // write lands on the edge where waitrequest is low
    ack_nxt  = (avs_read | avs_write) & ~ack_r;
    rd_nxt   = rd_r;
    ut3_nxt  = ut3_r;
    thr_nxt  = thr_r;
    c1_nxt   = c1_r;
    c2_nxt   = c2_r;
    sby_nxt_clear = c2_r[pmt_pkg::C2_SBY_RESET];
    if (sby_nxt_clear) begin
      c2_nxt[pmt_pkg::C2_SBY_RESET] = 1'b0;  // R10
    end
    if (avs_read && !ack_r) begin
      rd_nxt = {24'h000000, rd_sel(idx, ut3_r, thr_r, c1_r, c2_r)};
    end
    if (wr) begin
      if (idx == pmt_pkg::IDX_UT3_STOP) ut3_nxt = avs_writedata[7:0] & pmt_pkg::UT3_STOP_MASK;
      if (idx == pmt_pkg::IDX_THROTTLE) thr_nxt = avs_writedata[7:0];
      if (idx == pmt_pkg::IDX_CTL_ONE)  c1_nxt  = avs_writedata[7:0];
      if (idx == pmt_pkg::IDX_CTL_TWO)  c2_nxt  = avs_writedata[7:0];
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ut3_r <= pmt_pkg::RST_UT3_STOP;
      thr_r <= pmt_pkg::RST_THROTTLE;
      c1_r  <= pmt_pkg::RST_CTL_ONE;
      c2_r  <= pmt_pkg::RST_CTL_TWO;
      ack_r <= 1'b0;
      rd_r  <= 32'h00000000;
    end else begin
      ut3_r <= ut3_nxt;
      thr_r <= thr_nxt;
      c1_r  <= c1_nxt;
      c2_r  <= c2_nxt;
      ack_r <= ack_nxt;
      rd_r  <= rd_nxt;
    end
  end

  // us and ms enable pulses
  always_comb begin
    us_tick    = (us_div_r == 4'(pmt_pkg::US_CYCLES - 1));
    us_div_nxt = us_tick ? 4'h0 : us_div_r + 4'h1;
    ms_tick    = us_tick && (ms_div_r == 10'(MS_US - 1));
    ms_div_nxt = ms_div_r;
    if (us_tick) ms_div_nxt = ms_tick ? 10'h000 : ms_div_r + 10'h001;
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      us_div_r <= 4'h0;
      ms_div_r <= 10'h000;
    end else begin
      us_div_r <= us_div_nxt;
      ms_div_r <= ms_div_nxt;
    end
  end

  // enables and restart sources for each timer
  always_comb begin
    pm_en       = c1_r[pmt_pkg::C1_PM_EN];                                       // R5
    video_event = video_mem_access | (video_io_access & ~c2_r[pmt_pkg::C2_VIDEO_AB]);  // R14
    act         = activity_event | video_event;
    tmr_run[pmt_pkg::T_UT1] = pm_en & c1_r[pmt_pkg::C1_UT1_EN];                  // R8
    tmr_run[pmt_pkg::T_UT2] = pm_en & c1_r[pmt_pkg::C1_UT2_EN];                  // R8
    tmr_run[pmt_pkg::T_UT3] = pm_en & c1_r[pmt_pkg::C1_UT3_EN];                  // R8
    tmr_run[pmt_pkg::T_SUS] = pm_en & ~c2_r[pmt_pkg::C2_SUS_STOP];               // R11 R12
    tmr_run[pmt_pkg::T_SBY] = pm_en & ~c2_r[pmt_pkg::C2_SBY_RESET];              // R10
    tmr_rst[pmt_pkg::T_UT1] = act | (nmi & c2_r[pmt_pkg::C2_NMI_UT1]);           // R15 R17
    tmr_rst[pmt_pkg::T_UT2] = act;                                               // R17
    tmr_rst[pmt_pkg::T_UT3] = act;                                               // R17
    tmr_rst[pmt_pkg::T_SUS] = (act & c1_r[pmt_pkg::C1_SUS_MON])                  // R9
                              | (nmi & c2_r[pmt_pkg::C2_NMI_SUS]);               // R15
    tmr_rst[pmt_pkg::T_SBY] = act | (nmi & c2_r[pmt_pkg::C2_NMI_SBY]);           // R15
    tmr_code[pmt_pkg::T_UT1] = ut1_code;
    tmr_code[pmt_pkg::T_UT2] = ut2_code;
    tmr_code[pmt_pkg::T_UT3] = ut3_r[pmt_pkg::UT3_CODE_LSB +: 4];                // R1
    tmr_code[pmt_pkg::T_SUS] = suspend_code;
    tmr_code[pmt_pkg::T_SBY] = standby_code;
  end

  // one activity timer per slot
  for (genvar g = 0; g < pmt_pkg::N_TIMERS; g++) begin : g_tmr
    assign tif[g].run     = tmr_run[g];
    assign tif[g].restart = tmr_rst[g];
    assign tif[g].limit   = pmt_pkg::pmt_ms_ladder(tmr_code[g]);                 // R17
    assign tmr_exp[g]     = tif[g].expired;
    assign tmr_done[g]    = tif[g].done;
    pmt_timer u_tmr (
      .clock   (clock),
      .reset   (reset),
      .ms_tick (ms_tick),
      .t       (tif[g])
    );
  end

  // throttle low and high phases, stop delay, interrupt
  always_comb begin
    thr_st_nxt   = thr_st_r;
    thr_cnt_nxt  = thr_cnt_r;
    stop_cnt_nxt = stop_cnt_r;
    stop_nxt     = stop_r;
    irq_nxt      = pm_en & c1_r[pmt_pkg::C1_SW_EN] & suspend_irq_en & tmr_exp[pmt_pkg::T_SUS];  // R7 R16
    if (!pm_en || !throttle_en || (nmi && c2_r[pmt_pkg::C2_NMI_THR])) begin  // R15
      thr_st_nxt  = pmt_pkg::THR_IDLE;
      thr_cnt_nxt = '0;
    end else if (us_tick) begin
      unique case (thr_st_r)
        pmt_pkg::THR_IDLE: begin
          thr_st_nxt  = pmt_pkg::THR_LOW;
          thr_cnt_nxt = '0;
        end
        pmt_pkg::THR_LOW: begin
          thr_cnt_nxt = thr_cnt_r + 1'b1;
          if (thr_cnt_r + 1'b1 >= pmt_pkg::pmt_us_ladder(thr_r[pmt_pkg::THR_LOW_LSB +: 4])) begin  // R3
            thr_st_nxt  = pmt_pkg::THR_HIGH;
            thr_cnt_nxt = '0;
          end
        end
        pmt_pkg::THR_HIGH: begin
          thr_cnt_nxt = thr_cnt_r + 1'b1;
          if (thr_cnt_r + 1'b1 >= pmt_pkg::pmt_us_ladder(thr_r[pmt_pkg::THR_HIGH_LSB +: 4])) begin  // R4
            thr_st_nxt  = pmt_pkg::THR_LOW;
            thr_cnt_nxt = '0;
          end
        end
        default: thr_st_nxt = pmt_pkg::THR_IDLE;
      endcase
    end
    if (!(pm_en && c1_r[pmt_pkg::C1_HW_EN] && reduced_clock_state)) begin  // R6
      stop_cnt_nxt = '0;
      stop_nxt     = 1'b0;
    end else if (us_tick && !stop_r) begin
      stop_cnt_nxt = stop_cnt_r + 1'b1;
      if (stop_cnt_r + 1'b1 >= pmt_pkg::pmt_stop_delay(ut3_r[pmt_pkg::STOP_CODE_LSB +: 2])) begin  // R2
        stop_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      thr_st_r   <= pmt_pkg::THR_IDLE;
      thr_cnt_r  <= '0;
      stop_cnt_r <= '0;
      stop_r     <= 1'b0;
      irq_r      <= 1'b0;
    end else begin
      thr_st_r   <= thr_st_nxt;
      thr_cnt_r  <= thr_cnt_nxt;
      stop_cnt_r <= stop_cnt_nxt;
      stop_r     <= stop_nxt;
      irq_r      <= irq_nxt;
    end
  end

  // outputs
  assign management_interrupt = irq_r;
  assign clock_stop_request   = stop_r | (thr_st_r == pmt_pkg::THR_LOW);
  assign quick_power_down_en  = pm_en & c2_r[pmt_pkg::C2_QUICK_PD];  // R13
  assign timer_expired        = tmr_done;

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sby_self_clear_a: assert property (c2_r[pmt_pkg::C2_SBY_RESET] |=> !c2_r[pmt_pkg::C2_SBY_RESET])  // R10
    else $error("standby reset bit did not clear");
  pm_off_quiet_a: assert property (!pm_en |-> !quick_power_down_en ##1 !management_interrupt)  // R5
    else $error("activity while management disabled");
  sus_irq_a: assert property (tmr_exp[pmt_pkg::T_SUS] && pm_en && c1_r[pmt_pkg::C1_SW_EN] && suspend_irq_en
                              |=> management_interrupt)  // R16
    else $error("suspend expiry gave no interrupt");
  no_irq_masked_a: assert property (!suspend_irq_en |=> !management_interrupt)  // R16
    else $error("interrupt while masked");
  sus_stop_a: assert property (c2_r[pmt_pkg::C2_SUS_STOP] |=> !tmr_done[pmt_pkg::T_SUS])  // R11
    else $error("stopped suspend timer shows expiry");
  ut_disabled_a: assert property (!c1_r[pmt_pkg::C1_UT3_EN] |=> !tmr_done[pmt_pkg::T_UT3])  // R8
    else $error("disabled user timer expired");
  stop_hw_a: assert property (!c1_r[pmt_pkg::C1_HW_EN] |=> !stop_r)  // R6
    else $error("clock stop without hardware enable");
  reserved_zero_a: assert property (ut3_r[1:0] == 2'b00)  // R1
    else $error("reserved bits set");
  bus_ack_a: assert property ((avs_read || avs_write) && !ack_r |=> !avs_waitrequest)
    else $error("bus answer late");
  video_scope_a: assert property (video_io_access && !video_mem_access && c2_r[pmt_pkg::C2_VIDEO_AB]
                                  |-> !video_event)  // R14
    else $error("io access counted in narrow video scope");

  sus_expire_c: cover property (tmr_exp[pmt_pkg::T_SUS]);
  irq_c: cover property (management_interrupt);
  throttle_c: cover property (thr_st_r == pmt_pkg::THR_LOW ##1 thr_st_r == pmt_pkg::THR_HIGH);
  stop_c: cover property (stop_r);
endmodule

// [hw/pmt_pkg.sv]
package pmt_pkg;
  // register indices as printed; byte address is four times the index
  localparam logic [7:0] IDX_UT3_STOP = 8'h61;
  localparam logic [7:0] IDX_THROTTLE = 8'h62;
  localparam logic [7:0] IDX_CTL_ONE  = 8'h63;
  localparam logic [7:0] IDX_CTL_TWO  = 8'h64;
  // reset values
  localparam logic [7:0] RST_UT3_STOP = 8'h00;
  localparam logic [7:0] RST_THROTTLE = 8'h00;
  localparam logic [7:0] RST_CTL_ONE  = 8'h00;
  localparam logic [7:0] RST_CTL_TWO  = 8'h00;
  // writable bits of the user timer 3 register; bits 1:0 read as zero
  localparam logic [7:0] UT3_STOP_MASK = 8'hfc;
  // field positions, user timer 3 register
  localparam int UT3_CODE_LSB  = 4;
  localparam int STOP_CODE_LSB = 2;
  // field positions, throttle register
  localparam int THR_LOW_LSB   = 4;
  localparam int THR_HIGH_LSB  = 0;
  // field positions, control register one
  localparam int C1_PM_EN      = 7;
  localparam int C1_HW_EN      = 6;
  localparam int C1_SW_EN      = 5;
  localparam int C1_UT1_EN     = 3;
  localparam int C1_UT2_EN     = 2;
  localparam int C1_UT3_EN     = 1;
  localparam int C1_SUS_MON    = 0;
  // field positions, control register two
  localparam int C2_SBY_RESET  = 7;
  localparam int C2_SUS_STOP   = 6;
  localparam int C2_QUICK_PD   = 5;
  localparam int C2_VIDEO_AB   = 4;
  localparam int C2_NMI_THR    = 3;
  localparam int C2_NMI_UT1    = 2;
  localparam int C2_NMI_SUS    = 1;
  localparam int C2_NMI_SBY    = 0;
  // timing base
  localparam int CLK_HZ        = 10_000_000;
  localparam int US_PER_S      = 1_000_000;
  localparam int US_CYCLES     = (CLK_HZ + US_PER_S - 1) / US_PER_S;
  localparam int MS_US         = 1000;
  // timer slots in the timer array
  localparam int T_UT1 = 0;
  localparam int T_UT2 = 1;
  localparam int T_UT3 = 2;
  localparam int T_SUS = 3;
  localparam int T_SBY = 4;
  localparam int N_TIMERS = 5;
  localparam int LIM_W   = 24;
  localparam int US_W    = 20;
  // throttle phases
  typedef enum logic [1:0] {THR_IDLE, THR_LOW, THR_HIGH} pmt_thr_e;

  // user, suspend timer ladder in milliseconds
  function automatic logic [LIM_W-1:0] pmt_ms_ladder(input logic [3:0] code);
    logic [LIM_W-1:0] v;
    v = 24'h0000c8;
    unique case (code)
      4'h0: v = 24'h0000c8;  // 0.2 s
      4'h1: v = 24'h000190;  // 0.4 s
      4'h2: v = 24'h0003e8;  // 1 s
      4'h3: v = 24'h000708;  // 1.8 s
      4'h4: v = 24'h000dac;  // 3.5 s
      4'h5: v = 24'h001b58;  // 7 s
      4'h6: v = 24'h0036b0;  // 14 s
      4'h7: v = 24'h006d60;  // 28 s
      4'h8: v = 24'h00dac0;  // 56 s
      4'h9: v = 24'h01d4c0;  // 2 min
      4'ha: v = 24'h037a60;  // 3.8 min
      4'hb: v = 24'h06ddd0;  // 7.5 min
      4'hc: v = 24'h0dbba0;  // 15 min
      4'hd: v = 24'h1b7740;  // 30 min
      4'he: v = 24'h36ee80;  // 60 min
      4'hf: v = 24'h6ddd00;  // 120 min
    endcase
    return v;
  endfunction

  // throttle ladder in microseconds, fractions rounded up
  function automatic logic [US_W-1:0] pmt_us_ladder(input logic [3:0] code);
    logic [US_W-1:0] v;
    v = 20'h0001b;
    unique case (code)
      4'h0: v = 20'h0001b;  // 27 us
      4'h1: v = 20'h00036;  // 53.7 us
      4'h2: v = 20'h0006b;  // 107 us
      4'h3: v = 20'h000d7;  // 215 us
      4'h4: v = 20'h001ae;  // 430 us
      4'h5: v = 20'h0035c;  // 860 us
      4'h6: v = 20'h006a4;  // 1.7 ms
      4'h7: v = 20'h00d48;  // 3.4 ms
      4'h8: v = 20'h01b58;  // 7 ms
      4'h9: v = 20'h036b0;  // 14 ms
      4'ha: v = 20'h06d60;  // 28 ms
      4'hb: v = 20'h0d6d8;  // 55 ms
      4'hc: v = 20'h186a0;  // 0.1 s
      4'hd: v = 20'h30d40;  // 0.2 s
      4'he: v = 20'h61a80;  // 0.4 s
      4'hf: v = 20'hf4240;  // 1 s
    endcase
    return v;
  endfunction

  // reduced clock to clock stop wait in microseconds
  function automatic logic [US_W-1:0] pmt_stop_delay(input logic [1:0] code);
    logic [US_W-1:0] v;
    v = 20'h001ae;
    unique case (code)
      2'h0: v = 20'h001ae;  // 430 us
      2'h1: v = 20'h01b58;  // 7 ms
      2'h2: v = 20'h0d6d8;  // 55 ms
      2'h3: v = 20'hf4240;  // 1 s
    endcase
    return v;
  endfunction
endpackage

// [hw/pmt_timer_if.sv]
// link between the control block and one activity timer
interface pmt_timer_if;
  logic                          run;      // timer allowed to count
  logic                          restart;  // activity seen, count from zero
  logic [pmt_pkg::LIM_W-1:0]     limit;    // terminal count in ms ticks
  logic                          expired;  // one-cycle pulse at terminal count
  logic                          done;     // level, terminal count reached
  modport ctrl (output run, output restart, output limit, input expired, input done);
  modport tmr  (input run, input restart, input limit, output expired, output done);
endinterface

// [hw/pmt_timer.sv]
// activity timer counting ms ticks toward a terminal count
module pmt_timer (
  // clock and reset
  input  wire logic  clock,
  input  wire logic  reset,
  // time base
  input  wire logic  ms_tick,
  // control side
  pmt_timer_if.tmr   t
);
  logic [pmt_pkg::LIM_W-1:0] cnt_r;   // elapsed ms
  logic [pmt_pkg::LIM_W-1:0] cnt_nxt;
  logic                      done_r;  // held until restart or stop
  logic                      done_nxt;
  logic                      exp_nxt;

  // next count: stop clears, activity restarts, expiry holds
  always_comb begin
    cnt_nxt  = cnt_r;
    done_nxt = done_r;
    exp_nxt  = 1'b0;
    if (!t.run || t.restart) begin
      cnt_nxt  = '0;
      done_nxt = 1'b0;
    end else if (ms_tick && !done_r) begin
      if (cnt_r + 1'b1 >= t.limit) begin
        done_nxt = 1'b1;
        exp_nxt  = 1'b1;
      end
      cnt_nxt = cnt_r + 1'b1;
    end
  end

  // registers only
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cnt_r  <= '0;
      done_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      done_r <= done_nxt;
    end
  end

  assign t.expired = exp_nxt & ~done_r;
  assign t.done    = done_r;
endmodule

// [test/pmt_host_model.sv]
// host-side model: counts interrupt pulses and times the stop request
module pmt_host_model (
  // clock and reset
  input  wire logic clock,
  input  wire logic reset,
  // requests from the block
  input  wire logic management_interrupt,
  input  wire logic clock_stop_request,
  // what the host saw
  output int        irq_count,
  output int        stop_span,
  output int        run_span
);
  timeunit 1ns;
  timeprecision 1ns;
  logic prev_r;  // stop request one cycle ago
  int   len_r;   // cycles since the last change

  // a pulse is one cycle wide, so each high cycle is one interrupt
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      irq_count <= 0;
      stop_span <= 0;
      run_span  <= 0;
      prev_r    <= 1'b0;
      len_r     <= 0;
    end else begin
      if (management_interrupt === 1'b1) irq_count <= irq_count + 1;
      prev_r <= clock_stop_request;
      // at every change, keep the length of the span that just ended
      if (clock_stop_request !== prev_r) begin
        len_r <= 1;
        if (prev_r === 1'b1) stop_span <= len_r;
        else run_span <= len_r;
      end else begin
        len_r <= len_r + 1;
      end
    end
  end
endmodule

// [test/pm_timer_control_bench.sv]
// bench for the power-management timer control block
module pm_timer_control_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock, reset;               // clock and reset
  logic [9:0]  avs_address;                // bus request
  logic        avs_read, avs_write;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0]  avs_byteenable;
  logic        avs_waitrequest;
  logic [3:0]  ut1_code, ut2_code, suspend_code, standby_code;
  logic        suspend_irq_en, throttle_en; // neighbour controls
  logic        activity_event, video_mem_access, video_io_access, nmi, reduced_clock_state;
  logic        management_interrupt, clock_stop_request, quick_power_down_en;
  logic [4:0]  timer_expired;
  logic [7:0]  watch;                       // outputs a wait can poll
  int          irq_count, stop_span, run_span;
  int          bad_count, cmp_count;
  logic [7:0]  mreg [4];                    // register model
  logic [31:0] rd;
  logic [7:0]  v;

  assign watch = {clock_stop_request, 2'b00, timer_expired};

  // short ms tick keeps the timers within the run length
  pmt_control #(.MS_US(2)) u_pmt_control (
    .clock(clock), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ut1_code(ut1_code),
    .ut2_code(ut2_code), .suspend_code(suspend_code), .standby_code(standby_code),
    .suspend_irq_en(suspend_irq_en), .throttle_en(throttle_en), .activity_event(activity_event),
    .video_mem_access(video_mem_access), .video_io_access(video_io_access), .nmi(nmi),
    .reduced_clock_state(reduced_clock_state), .management_interrupt(management_interrupt),
    .clock_stop_request(clock_stop_request), .quick_power_down_en(quick_power_down_en),
    .timer_expired(timer_expired));

  pmt_host_model u_pmt_host_model (
    .clock(clock), .reset(reset), .management_interrupt(management_interrupt),
    .clock_stop_request(clock_stop_request), .irq_count(irq_count),
    .stop_span(stop_span), .run_span(run_span));

  // verdict and end of run
  task automatic test_done();
    if (bad_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // one comparison
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // bus write, held until waitrequest is seen low
  task automatic bus_write(input logic [7:0] idx, input logic [7:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clock);
    avs_address    <= {idx, 2'b00};
    avs_writedata  <= {24'h000000, d};
    avs_byteenable <= be;
    avs_write      <= 1'b1;
    do begin @(posedge clock); n++; end while (avs_waitrequest !== 1'b0 && n < 50);
    avs_write <= 1'b0;
    if (n >= 50) bad_count++;
  endtask

  // bus read, data taken at the accepting edge
  task automatic bus_read(input logic [7:0] idx, output logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    avs_address <= {idx, 2'b00};
    avs_read    <= 1'b1;
    do begin @(posedge clock); n++; end while (avs_waitrequest !== 1'b0 && n < 50);
    d = avs_readdata;
    avs_read <= 1'b0;
    if (n >= 50) bad_count++;
  endtask

  // wait for an output to rise and check the cycle count lies in a window
  task automatic rise_at(input int b, input int lo, input int hi);
    int n;
    n = 0;
    while (watch[b] !== 1'b1 && n <= hi) begin @(posedge clock); n++; end
    check(32'(n >= lo && n <= hi), 32'h1);
  endtask

  // clock source
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // watchdog, well beyond the expected run
  initial begin
    repeat (90000) @(posedge clock);
    bad_count++;
    test_done();
  end

  // main sequence
  initial begin
    reset = 1'b1; avs_address = '0; avs_read = 1'b0; avs_write = 1'b0;
    avs_writedata = '0; avs_byteenable = '0; ut1_code = 4'h0; ut2_code = 4'h0;
    suspend_code = 4'h0; standby_code = 4'h0; suspend_irq_en = 1'b0; throttle_en = 1'b0;
    activity_event = 1'b0; video_mem_access = 1'b0; video_io_access = 1'b0; nmi = 1'b0;
    reduced_clock_state = 1'b0; bad_count = 0; cmp_count = 0;
    void'($urandom(19583));
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    // reset values, then an unmapped place
    for (int i = 0; i < 4; i++) begin
      bus_read(8'h61 + 8'(i), rd);
      check(rd, 32'h00000000);
      mreg[i] = 8'h00;
    end
    bus_write(8'h65, 8'hff, 4'h1);
    bus_read(8'h65, rd);
    check(rd, 32'h00000000);
    // random fields; reserved bits of 0x61 and the self-clearing reset bit read zero
    for (int k = 0; k < 12; k++) begin
      v = 8'($urandom);
      bus_write(8'h61 + 8'(k % 4), v, 4'h1);
      mreg[k % 4] = (k % 4 == 0) ? (v & 8'hfc) : (k % 4 == 3) ? (v & 8'h7f) : v;
      bus_write(8'h61 + 8'(k % 4), ~v, 4'h0);
      bus_read(8'h61 + 8'(k % 4), rd);
      check(rd, {24'h000000, mreg[k % 4]});
    end
    // quick power-down needs both the master and its own enable
    for (int q = 0; q < 4; q++) begin
      bus_write(8'h63, {q[1], 7'h00}, 4'h1);
      bus_write(8'h64, {2'b00, q[0], 5'h00}, 4'h1);
      @(posedge clock);
      check(32'(quick_power_down_en), 32'(q[1] & q[0]));
    end
    // user timers: ut1 0.2 s, ut3 0.4 s, ut2 left disabled; activity restarts
    bus_write(8'h61, 8'h10, 4'h1);
    bus_write(8'h63, 8'h8a, 4'h1);
    repeat (2000) @(posedge clock);
    activity_event <= 1'b1;
    @(posedge clock);
    activity_event <= 1'b0;
    rise_at(0, 3800, 4400);
    rise_at(2, 3600, 4400);
    check(32'(timer_expired[1]), 32'h0);
    // suspend: interrupt at expiry, again after stop and restart, none when not enabled
    bus_write(8'h63, 8'ha0, 4'h1);
    suspend_irq_en <= 1'b1;
    for (int s = 0; s < 3; s++) begin
      if (s == 2) suspend_irq_en <= 1'b0;
      bus_write(8'h64, 8'h40, 4'h1);
      repeat (3) @(posedge clock);
      check(32'(timer_expired[3]), 32'h0);
      bus_write(8'h64, 8'h00, 4'h1);
      rise_at(3, 3800, 4400);
      repeat (5) @(posedge clock);
      check(32'(irq_count), 32'((s < 2) ? s + 1 : 2));
    end
    // stop request after 430 us in the reduced clock state
    bus_write(8'h61, 8'h00, 4'h1);
    bus_write(8'h63, 8'hc0, 4'h1);
    reduced_clock_state <= 1'b1;
    rise_at(7, 4200, 4400);
    reduced_clock_state <= 1'b0;
    repeat (5) @(posedge clock);
    check(32'(clock_stop_request), 32'h0);
    // throttle: low time 54 us, high time 27 us
    bus_write(8'h62, 8'h10, 4'h1);
    bus_write(8'h63, 8'h80, 4'h1);
    throttle_en <= 1'b1;
    repeat (3000) @(posedge clock);
    check(32'(stop_span >= 530 && stop_span <= 550), 32'h1);
    check(32'(run_span >= 260 && run_span <= 280), 32'h1);
    // standby: reset bit clears it, narrow video scope ignores io, nmi restarts it
    check(32'(timer_expired[4]), 32'h1);
    bus_write(8'h64, 8'h91, 4'h1);
    repeat (3) @(posedge clock);
    check(32'(timer_expired[4]), 32'h0);
    repeat (1000) @(posedge clock);
    video_io_access <= 1'b1;
    @(posedge clock);
    video_io_access <= 1'b0;
    rise_at(4, 2800, 3400);
    nmi <= 1'b1;
    @(posedge clock);
    nmi <= 1'b0;
    repeat (3) @(posedge clock);
    check(32'(timer_expired[4]), 32'h0);
    test_done();
  end
endmodule
